//--- design/sar_adc_conversion_control.sv
// conversion sequencing, done flag and result buffering for a 12-bit sar converter
// Operation
// - conversion starts on software start bit or external frame-start pulse
// - continuous mode runs with no frame-start pulse at all
// - no conversion starts until the 10 us power-up wait has elapsed
// - completion sets a status bit and raises conversion-done
// - conversion-done holds until the result is read by cpu or dma
// - conversion-done serves as interrupt source or dma request
// - single-conversion select picks continuous or one conversion per trigger
// - continuous results flow out by dma back to back without cpu
// - sample input then resolve bits msb to lsb by binary search
// - result is 12 bits wide; sample rate up to 700 ksps
`timescale 1ns/10ps
module sar_adc_conversion_control
   import sar_ctrl_pkg::*;
#(
   parameter int PWRUP_WAIT = PWRUP_CYCLES,
   parameter int BITS       = RES_BITS
)
(
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            clkEn,
   input  wire logic            wake,
   input  wire logic            startBit,
   input  wire logic            frameStart,
   input  wire logic            singleSel,
   input  wire logic            compOut,
   output logic                 sampleEn,
   output logic [BITS-1:0]      dacCode,
   output logic                 statusDone,
   output logic                 convDone,
   output logic [BITS-1:0]      result,
   input  wire logic            resultRead,
   output logic                 busy,
   output logic                 ready
);
   localparam int PW = $clog2(PWRUP_WAIT + 1);
   localparam int BW = $clog2(BITS + 1);

   conv_state_t      state_ff;
   conv_state_t      nxt_state;
   logic [PW-1:0]    pwrCnt_ff;
   logic [BW-1:0]    bitIdx_ff;
   logic [1:0]       smpCnt_ff;
   logic [BITS-1:0]  trial_ff;
   logic [1:0]       sofSync_ff;
   logic             sofLast_ff;
   logic [1:0]       wakeSync_ff;
   logic [1:0]       cmpSync_ff;
   logic             sampleEn_ff;
   logic             busy_ff;
   logic             ready_ff;
   logic             statusDone_ff;
   logic [BITS-1:0]  result_ff;
   wire              sofPulse;
   wire              startReq;
   wire              bitTaken;
   wire              lastBit;
   wire              bitDecide;
   wire              fifoInReady;
   wire              fifoOutValid;
   wire [BITS-1:0]   fifoOutData;
   wire              drainFifo;
   wire              pushResult;

   // pin inputs pass two flops; edge detect reads the second stage only
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sofSync_ff  <= 2'h0;
         sofLast_ff  <= 1'b0;
         wakeSync_ff <= 2'h0;
         cmpSync_ff  <= 2'h0;
      end
      else if (clkEn)
      begin
         sofSync_ff  <= {sofSync_ff[0], frameStart};
         sofLast_ff  <= sofSync_ff[1];
         wakeSync_ff <= {wakeSync_ff[0], wake};
         cmpSync_ff  <= {cmpSync_ff[0], compOut};
      end
   end

   // start decode: continuous mode needs no trigger at all
   assign sofPulse = sofSync_ff[1] && !sofLast_ff;
   assign startReq = !singleSel || startBit || sofPulse;
   // comparator high means the trial level is below the input, keep the bit
   assign bitTaken = cmpSync_ff[1];
   assign lastBit  = (bitIdx_ff == '0);
   // decide only once the comparator answer for this trial is through both sync stages
   assign bitDecide = (smpCnt_ff == 2'(BIT_CYCLES - 1));
   assign pushResult = (state_ff == ST_STORE);
   // a result read pops the buffer; the next waiting result follows next cycle
   assign drainFifo = resultRead && statusDone_ff;

   // sequencing; requests outside idle fall on the floor
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_POWERUP: if (pwrCnt_ff == PW'(PWRUP_WAIT)) nxt_state = ST_IDLE;
         ST_IDLE:    if (startReq) nxt_state = ST_SAMPLE;
         ST_SAMPLE:  if (smpCnt_ff == 2'(SAMPLE_CYCLES - 1)) nxt_state = ST_SEARCH;
         ST_SEARCH:  if (lastBit && bitDecide) nxt_state = ST_STORE;
         ST_STORE:   if (fifoInReady) nxt_state = ST_IDLE;
         default:    nxt_state = ST_POWERUP;
      endcase
   end

   // state, power-up timer and bit search
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff  <= ST_POWERUP;
         pwrCnt_ff <= '0;
         bitIdx_ff <= '0;
         smpCnt_ff <= 2'h0;
         trial_ff  <= '0;
      end
      else if (clkEn)
      begin
         // wake from sleep restarts the power-up wait
         if (wakeSync_ff[1])
         begin
            state_ff  <= ST_POWERUP;
            pwrCnt_ff <= '0;
         end
         else
         begin
            state_ff <= nxt_state;
            if (state_ff == ST_POWERUP)
               pwrCnt_ff <= pwrCnt_ff + 1'b1;
         end
         unique case (state_ff)
            ST_IDLE:
            begin
               smpCnt_ff <= 2'h0;
               bitIdx_ff <= BW'(BITS - 1);
               trial_ff  <= '0;
            end
            ST_SAMPLE:
            begin
               smpCnt_ff <= smpCnt_ff + 2'h1;
               if (smpCnt_ff == 2'(SAMPLE_CYCLES - 1))
               begin
                  smpCnt_ff               <= 2'h0;
                  trial_ff[BITS-1]        <= 1'b1;
               end
            end
            ST_SEARCH:
            begin
               // three cycles a bit: one for the trial to reach the comparator and
               // two for its synchroniser; fewer would decide on the previous trial
               smpCnt_ff <= smpCnt_ff + 2'h1;
               if (bitDecide)
               begin
                  smpCnt_ff          <= 2'h0;
                  trial_ff[bitIdx_ff] <= bitTaken;
                  if (!lastBit)
                  begin
                     trial_ff[bitIdx_ff - 1'b1] <= 1'b1;
                     bitIdx_ff                   <= bitIdx_ff - 1'b1;
                  end
               end
            end
            default:
            begin
               smpCnt_ff <= smpCnt_ff;
            end
         endcase
      end
   end

   // result buffer: a full buffer stalls the converter in the store state
   sar_result_fifo #(
      .WIDTH (BITS),
      .DEPTH (FIFO_DEPTH)
   ) resultFifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .clkEn    (clkEn),
      .inValid  (pushResult),
      .inReady  (fifoInReady),
      .inData   (trial_ff),
      .outValid (fifoOutValid),
      .outReady (drainFifo || !statusDone_ff),
      .outData  (fifoOutData)
   );

   // status and done: set by a presented result, cleared by its read
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         statusDone_ff <= 1'b0;
         result_ff     <= RESULT_RST;
         sampleEn_ff   <= 1'b0;
         busy_ff       <= 1'b0;
         ready_ff      <= 1'b0;
      end
      else if (clkEn)
      begin
         // a new result loaded in the same cycle as a read keeps done high
         if (fifoOutValid && (drainFifo || !statusDone_ff))
         begin
            statusDone_ff <= 1'b1;
            result_ff     <= fifoOutData;
         end
         else if (drainFifo)
            statusDone_ff <= 1'b0;
         sampleEn_ff <= (nxt_state == ST_SAMPLE) && !wakeSync_ff[1];
         busy_ff     <= (nxt_state != ST_IDLE) && (nxt_state != ST_POWERUP);
         ready_ff    <= (nxt_state != ST_POWERUP) && !wakeSync_ff[1];
      end
   end

   assign sampleEn   = sampleEn_ff;
   assign dacCode    = trial_ff;
   assign statusDone = statusDone_ff;
   assign convDone   = statusDone_ff;
   assign result     = result_ff;
   assign busy       = busy_ff;
   assign ready      = ready_ff;
endmodule

//--- design/sar_ctrl_pkg.sv
// constants shared by the successive approximation conversion control
package sar_ctrl_pkg;
   localparam int          RES_BITS      = 12;          // result width
   localparam int          CLK_MHZ       = 100;         // control clock rate
   localparam int          PWRUP_WAIT_NS = 10000;       // power-up wait, 10 us
   localparam int          PWRUP_CYCLES  = (PWRUP_WAIT_NS * CLK_MHZ + 999) / 1000;
   localparam int          SAMPLE_CYCLES = 2;           // cycles the input is sampled
   localparam int          BIT_CYCLES    = 3;           // cycles a bit: trial settle plus comparator sync
   localparam int          FIFO_DEPTH    = 4;           // result buffer depth
   localparam logic [11:0] RESULT_RST    = 12'h000;     // result reset value

   typedef enum logic [2:0]
   {
      ST_POWERUP = 3'b000,
      ST_IDLE    = 3'b001,
      ST_SAMPLE  = 3'b010,
      ST_SEARCH  = 3'b011,
      ST_STORE   = 3'b100
   } conv_state_t;
endpackage

//--- design/sar_result_fifo.sv
// small result buffer with valid and ready on both sides
`timescale 1ns/10ps
module sar_result_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 4
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             clkEn,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wrPtr_ff;
   logic [AW-1:0]    rdPtr_ff;
   logic [AW:0]      count_ff;
   logic [WIDTH-1:0] rdData_ff;
   logic             rdValid_ff;
   wire              pushEn;
   wire              popEn;
   wire              loadOut;
   wire              memEmpty;

   // output register drains the memory whenever it is empty or being taken
   assign memEmpty = (count_ff == '0);
   assign loadOut  = !memEmpty && (!rdValid_ff || outReady);
   assign popEn    = loadOut;
   assign pushEn   = inValid && inReady;
   assign inReady  = (count_ff != (AW+1)'(DEPTH));
   assign outValid = rdValid_ff;
   assign outData  = rdData_ff;

   // storage and pointers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wrPtr_ff   <= '0;
         rdPtr_ff   <= '0;
         count_ff   <= '0;
         rdData_ff  <= '0;
         rdValid_ff <= 1'b0;
      end
      else if (clkEn)
      begin
         if (pushEn)
         begin
            mem_ff[wrPtr_ff] <= inData;
            wrPtr_ff         <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
         end
         if (popEn)
         begin
            rdData_ff <= mem_ff[rdPtr_ff];
            rdPtr_ff  <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
         end
         count_ff   <= count_ff + (AW+1)'(pushEn) - (AW+1)'(popEn);
         rdValid_ff <= loadOut || (rdValid_ff && !outReady);
      end
   end
endmodule

//--- dv/sar_adc_conversion_control_props.sv
// port assertions for the conversion control
`timescale 1ns/10ps
module sar_ctrl_checker #(
   parameter int PWRUP_WAIT = 20,
   parameter int BITS       = 12
)
(
   input wire logic            clk,
   input wire logic            rst_n,
   input wire logic            clkEn,
   input wire logic            ready,
   input wire logic            sampleEn,
   input wire logic [BITS-1:0] dacCode,
   input wire logic            statusDone,
   input wire logic            convDone,
   input wire logic            resultRead
);
   int waitCnt_ff;
   default clocking @(posedge clk); endclocking
   // cycle counts below assume an enabled clock; a paced enable is checked by the bench
   default disable iff (!rst_n || !clkEn);

   // enabled cycles spent not ready; cleared once ready so a wake restarts it
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         waitCnt_ff <= 0;
      else if (ready)
         waitCnt_ff <= 0;
      else if (clkEn)
         waitCnt_ff <= waitCnt_ff + 1;
   end

   // two sample cycles, then no new sample for the first eight cycles of the bit search
   sequence sampleWin;
      sampleEn [*2] ##1 !sampleEn;
   endsequence
   sequence searchQuiet;
      !sampleEn [*8];
   endsequence

   a_sample_len: assert property ($rose(sampleEn) |-> sampleWin)
      else $error("sample phase not two cycles");
   a_msb_first: assert property ($fell(sampleEn) |-> dacCode == {1'b1, {(BITS-1){1'b0}}})
      else $error("first trial is not the top bit");
   a_no_restart: assert property ($fell(sampleEn) |-> searchQuiet)
      else $error("new sample during the search");
   a_no_early: assert property (!ready |-> !sampleEn)
      else $error("sample before power-up wait");
   a_wait_len: assert property ($rose(ready) |-> waitCnt_ff >= PWRUP_WAIT - 1)
      else $error("power-up wait too short");
   a_done_twins: assert property (convDone == statusDone)
      else $error("done and status differ");
   a_done_bound: assert property ($rose(sampleEn) |-> ##[38:44] convDone)
      else $error("conversion did not complete in time");
   a_done_holds: assert property (convDone && !resultRead |=> convDone)
      else $error("done dropped without a read");
endmodule

bind sar_adc_conversion_control sar_ctrl_checker #(.PWRUP_WAIT(PWRUP_WAIT), .BITS(BITS)) chk (
   .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .ready(ready), .sampleEn(sampleEn), .dacCode(dacCode),
   .statusDone(statusDone), .convDone(convDone), .resultRead(resultRead));

//--- dv/sar_adc_conversion_control_tb_top.sv
// self-checking bench for the conversion control
`timescale 1ns/10ps
module sar_adc_conversion_control_tb_top;
   import sar_ctrl_pkg::*;
   localparam int PW = 20;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        startBit = 1'b1;
   logic        frameStart = 1'b0;
   logic        singleSel = 1'b1;
   logic        resultRead = 1'b0;
   logic        clkEn = 1'b1;
   logic        wake = 1'b0;
   logic [11:0] vin = 12'h7e1;
   logic        compOut, sampleEn, statusDone, convDone, busy, ready;
   logic [11:0] dacCode, result;
   int          fail_count = 0;
   int          total_checks = 0;

   always #5 clk = ~clk;

   sar_adc_conversion_control #(.PWRUP_WAIT(PW)) uut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .wake(wake),
      .startBit(startBit), .frameStart(frameStart), .singleSel(singleSel), .compOut(compOut),
      .sampleEn(sampleEn), .dacCode(dacCode), .statusDone(statusDone), .convDone(convDone),
      .result(result), .resultRead(resultRead), .busy(busy), .ready(ready));
   sar_analog_model model (.dacCode(dacCode), .vin(vin), .compOut(compOut));

   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // a wait that runs out counts as a mismatch and ends the run
   task automatic timeout(input string what);
      fail_count++;
      $display("MISMATCH %s expected event seen timeout", what);
      print_verdict();
   endtask

   // bounded wait for done; running out ends the run
   task automatic waitDone();
      int n;
      @(negedge clk);
      for (n = 0; n < 200 && convDone !== 1'b1; n++)
         @(negedge clk);
      if (n == 200)
         timeout("convDone");
   endtask

   // one enabled edge in eight paces the control logic at 12.5 MHz
   task automatic tick(input logic rd, input logic st);
      @(posedge clk);
      clkEn <= 1'b1;
      resultRead <= rd;
      startBit <= st;
      @(posedge clk);
      clkEn <= 1'b0;
      resultRead <= 1'b0;
      startBit <= 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
   endtask

   // a full conversion and read with the control clock below its limit
   task automatic t_slow(input logic [11:0] v);
      int n;
      @(posedge clk);
      vin <= v;
      tick(1'b0, 1'b1);
      for (n = 0; n < 80 && convDone !== 1'b1; n++)
         tick(1'b0, 1'b0);
      if (n == 80)
         timeout("slowDone");
      check("slowResult", result, v);
      tick(1'b1, 1'b0);
      check("slowClr", convDone, 1'b0);
      @(posedge clk);
      clkEn <= 1'b1;
      $display("test slow clock finished");
   endtask

   // one-cycle read pulse; last means nothing else is queued behind it
   task automatic readOne(input logic [11:0] exp, input logic last);
      @(negedge clk);
      check("result", result, exp);
      @(posedge clk);
      resultRead <= 1'b1;
      @(posedge clk);
      resultRead <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      if (last)
      begin
         check("doneClr", convDone, 1'b0);
         check("statusClr", statusDone, 1'b0);
      end
   endtask

   // start held through the wait is refused until ready, then taken; a wake pulse restarts the wait
   task automatic t_powerup(input logic doWake);
      int n;
      if (doWake)
      begin
         @(posedge clk);
         vin <= 12'h7e1;
         wake <= 1'b1;
         @(posedge clk);
         wake <= 1'b0;
         for (n = 0; n < 10 && ready !== 1'b0; n++)
            @(negedge clk);
         if (n == 10)
            timeout("readyDrop");
         @(posedge clk);
         startBit <= 1'b1;
      end
      @(negedge clk);
      for (n = 0; n < 100 && ready !== 1'b1; n++)
      begin
         check("busyEarly", busy, 1'b0);
         @(negedge clk);
      end
      if (n == 100)
         timeout("ready");
      check("waitLong", n >= PW, 1'b1);
      @(posedge clk);
      startBit <= 1'b0;
      waitDone();
      readOne(12'h7e1, 1'b1);
      $display("test powerup finished");
   endtask

   // single mode: software or frame start, a second start mid-conversion is ignored
   task automatic t_once(input logic [11:0] v, input logic useFrame);
      @(posedge clk);
      vin <= v;
      startBit <= !useFrame;
      frameStart <= useFrame;
      repeat (4) @(posedge clk);
      frameStart <= 1'b0;
      startBit <= 1'b1;
      @(posedge clk);
      startBit <= 1'b0;
      waitDone();
      check("status", statusDone, 1'b1);
      repeat (5)
      begin
         @(negedge clk);
         check("doneHeld", convDone, 1'b1);
      end
      readOne(v, 1'b1);
      repeat (50) @(negedge clk);
      check("oneShot", convDone, 1'b0);
      $display("test once %h finished", v);
   endtask

   // continuous mode fills the buffer untriggered, then reads drain it
   task automatic t_continuous();
      int n;
      @(posedge clk);
      vin <= 12'h3c7;
      singleSel <= 1'b0;
      repeat (300) @(posedge clk);
      singleSel <= 1'b1;
      repeat (60) @(negedge clk);
      for (n = 0; n < 10 && convDone === 1'b1; n++)
         readOne(12'h3c7, 1'b0);
      check("drained", n >= FIFO_DEPTH, 1'b1);
      check("empty", convDone, 1'b0);
      $display("test continuous finished");
   endtask

   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_powerup(1'b0);
      t_once(12'hfff, 1'b0);
      t_once(12'h000, 1'b1);
      t_once(12'ha5c, 1'b0);
      t_once(12'h5a3, 1'b1);
      t_powerup(1'b1);
      t_slow(12'h6b2);
      t_continuous();
      print_verdict();
   end
endmodule

//--- dv/sar_analog_model.sv
// comparator and trial dac standing in for the analog input
`timescale 1ns/10ps
module sar_analog_model
(
   input  wire logic [11:0] dacCode,
   input  wire logic [11:0] vin,
   output logic             compOut
);
   // keep the trial bit while the input is at or above the trial code
   assign compOut = (vin >= dacCode);
endmodule
